//--- logic/gcc_gain_control_config.sv
// Gain control configuration registers and live channel gain sequencer
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Threshold field bits 7-4, reset 0111b
// - Enhancer gain field bits 3-0, reset 1011b
// - Target level field bits 7-4, reset 1110b
// - Controller gain field bits 3-0, reset 0111b
// - Method 0 applies new gain at once
// - Method 1 applies gain at low-artifact moment
// - Method 2 ramps 0.5 dB per 20 us
// - Method 3 ramps 0.5 dB per 40 us
// - Bit 5 stored, bits 4-0 read zero
module gcc_gain_control_config #(
    parameter int ZC_TIMEOUT_CYCLES = gcc_pkg::GCC_ZC_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Register access from the control port slave
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output logic            reg_hit,
    // Channel gain request from the channel settings
    input  wire logic [6:0] gain_target,
    input  wire logic       gain_load,
    input  wire logic       zero_cross,
    input  wire logic       impedance_20k,
    // Fields for the gain-control engines
    output logic      [3:0] enhancer_trigger_threshold,
    output logic      [3:0] enhancer_max_gain,
    output logic      [3:0] auto_gain_target_level,
    output logic      [3:0] auto_gain_max_gain,
    output logic      [1:0] live_gain_change_method,
    // Decoded levels in dB
    output logic      [6:0] enhancer_threshold_db,
    output logic      [6:0] enhancer_max_gain_db,
    output logic      [6:0] auto_gain_target_db,
    output logic      [6:0] auto_gain_max_gain_db,
    // Applied channel gain and status
    output logic      [6:0] gain_applied,
    output logic            gain_busy,
    output logic            gain_step,
    output logic            gain_limit_warn
);
    localparam int ZCW = $clog2(ZC_TIMEOUT_CYCLES + 1);
    localparam int HI  = gcc_pkg::GCC_HI_NIB_LSB;
    localparam int LO  = gcc_pkg::GCC_LO_NIB_LSB;
    localparam int ML  = gcc_pkg::GCC_METHOD_LSB;
    localparam int SB  = gcc_pkg::GCC_SPARE_RW_BIT;

    // Register storage
    logic [7:0] range_enhancer_cfg_reg;  // Threshold and enhancer gain
    logic [7:0] auto_gain_cfg_reg;       // Target level and controller gain
    logic [1:0] method_reg;              // Gain change method
    logic       spare_reg;               // Writable spare bit
    logic [7:0] gain_change_cfg;         // Assembled read view
    logic [2:0] reg_sel;                 // One-hot select of reg_addr

    // Read port flops
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    logic       hit_reg;

    // Decoded levels, registered
    logic [6:0] thr_db;
    logic [6:0] emax_db;
    logic [6:0] atgt_db;
    logic [6:0] amax_db;
    logic [6:0] thr_db_reg;
    logic [6:0] emax_db_reg;
    logic [6:0] atgt_db_reg;
    logic [6:0] amax_db_reg;

    // Sequencer
    gcc_pkg::gcc_state_t state_reg;      // Current phase
    logic [6:0]          target_reg;     // Gain being moved toward
    logic [6:0]          applied_reg;    // Gain in force
    logic                step_reg;       // One ramp step was taken
    logic                warn_reg;       // Soft-step request beyond limit
    logic [ZCW-1:0]      zc_cnt_reg;     // Wait for a zero crossing
    logic                zc_timeout;
    logic                tick;
    logic                soft_sel;
    logic [6:0]          limit;

    // One-hot register select, shared by writes and reads
    function automatic logic [2:0] gcc_sel(input logic [7:0] addr);
        gcc_sel = {addr == gcc_pkg::GCC_GAIN_CHANGE_CFG_OFS,
                   addr == gcc_pkg::GCC_AUTO_GAIN_CFG_OFS,
                   addr == gcc_pkg::GCC_RANGE_ENHANCER_CFG_OFS};
    endfunction

    // Decode once so each register process can pick its own select bit
    assign reg_sel = gcc_sel(reg_addr);

    // Enhancer settings; reserved codes are stored as written
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            range_enhancer_cfg_reg <= gcc_pkg::GCC_RANGE_ENHANCER_CFG_RST;
        end else if (reg_wr && reg_sel[0]) begin
            range_enhancer_cfg_reg <= reg_wdata;
        end
    end

    // Automatic gain controller settings
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            auto_gain_cfg_reg <= gcc_pkg::GCC_AUTO_GAIN_CFG_RST;
        end else if (reg_wr && reg_sel[1]) begin
            auto_gain_cfg_reg <= reg_wdata;
        end
    end

    // Gain change register: only bits 7-5 hold state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            method_reg <= gcc_pkg::GCC_GAIN_CHANGE_CFG_RST[ML+1:ML];
            spare_reg  <= gcc_pkg::GCC_GAIN_CHANGE_CFG_RST[SB];
        end else if (reg_wr && reg_sel[2]) begin
            method_reg <= reg_wdata[ML+1:ML];
            spare_reg  <= reg_wdata[SB];
        end
    end

    // Read-only spare bits always read as zero, whatever was written
    assign gain_change_cfg = {method_reg, spare_reg, 5'h00};

    // Read data is registered; unmapped offsets answer zero with no hit,
    // so the map above can merge the answers of several banks
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            hit_reg    <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                hit_reg <= |gcc_sel(reg_addr);
                case (gcc_sel(reg_addr))
                    3'h1:    rdata_reg <= range_enhancer_cfg_reg;
                    3'h2:    rdata_reg <= auto_gain_cfg_reg;
                    3'h4:    rdata_reg <= gain_change_cfg;
                    default: rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    // Field views for the engines
    assign enhancer_trigger_threshold = range_enhancer_cfg_reg[HI+3:HI];
    assign enhancer_max_gain          = range_enhancer_cfg_reg[LO+3:LO];
    assign auto_gain_target_level     = auto_gain_cfg_reg[HI+3:HI];
    assign auto_gain_max_gain         = auto_gain_cfg_reg[LO+3:LO];
    assign live_gain_change_method    = method_reg;

    // Code to dB translation
    gcc_level_decode u_decode (
        .thr_code  (range_enhancer_cfg_reg[HI+3:HI]),
        .emax_code (range_enhancer_cfg_reg[LO+3:LO]),
        .atgt_code (auto_gain_cfg_reg[HI+3:HI]),
        .amax_code (auto_gain_cfg_reg[LO+3:LO]),
        .thr_db    (thr_db),
        .emax_db   (emax_db),
        .atgt_db   (atgt_db),
        .amax_db   (amax_db)
    );

    // Register the decoded levels so the engines see clean flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            thr_db_reg  <= 7'h00;
            emax_db_reg <= 7'h00;
            atgt_db_reg <= 7'h00;
            amax_db_reg <= 7'h00;
        end else begin
            thr_db_reg  <= thr_db;
            emax_db_reg <= emax_db;
            atgt_db_reg <= atgt_db;
            amax_db_reg <= amax_db;
        end
    end

    // Soft-step pace; 0.5 dB per pulse
    assign soft_sel = method_reg[1];

    gcc_step_tick u_tick (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (state_reg == gcc_pkg::GCC_ST_RAMP),
        .slow     (method_reg == gcc_pkg::GCC_METHOD_STEP_SLOW),
        .tick     (tick)
    );

    // Zero-crossing wait; a silent channel may never cross, so give up
    assign zc_timeout = (zc_cnt_reg == ZCW'(ZC_TIMEOUT_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            zc_cnt_reg <= '0;
        end else if (state_reg != gcc_pkg::GCC_ST_WAIT_ZC || gain_load) begin
            zc_cnt_reg <= '0;
        end else if (!zc_timeout) begin
            zc_cnt_reg <= zc_cnt_reg + 1'b1;
        end
    end

    // Latch each new request; a new one replaces any move in progress
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            target_reg <= 7'h00;
        end else if (gain_load) begin
            target_reg <= gain_target;
        end
    end

    // Sequencer phase; the method in force at the request decides the path
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= gcc_pkg::GCC_ST_IDLE;
        end else if (gain_load) begin
            case (method_reg)
                gcc_pkg::GCC_METHOD_IMMEDIATE: state_reg <= gcc_pkg::GCC_ST_IDLE;
                gcc_pkg::GCC_METHOD_REDUCED:   state_reg <= gcc_pkg::GCC_ST_WAIT_ZC;
                default:                       state_reg <= gcc_pkg::GCC_ST_RAMP;
            endcase
        end else begin
            case (state_reg)
                gcc_pkg::GCC_ST_WAIT_ZC: begin
                    // Switch at the crossing, or at the timeout
                    if (zero_cross || zc_timeout) begin
                        state_reg <= gcc_pkg::GCC_ST_IDLE;
                    end
                end
                gcc_pkg::GCC_ST_RAMP: begin
                    // Done once the gain in force meets the target
                    if (applied_reg == target_reg) begin
                        state_reg <= gcc_pkg::GCC_ST_IDLE;
                    end
                end
                default: state_reg <= gcc_pkg::GCC_ST_IDLE;
            endcase
        end
    end

    // Gain in force: jump, jump at crossing, or one half-dB per pulse
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            applied_reg <= 7'h00;
        end else if (gain_load) begin
            if (method_reg == gcc_pkg::GCC_METHOD_IMMEDIATE) begin
                applied_reg <= gain_target;
            end
        end else if (state_reg == gcc_pkg::GCC_ST_WAIT_ZC) begin
            if (zero_cross || zc_timeout) begin
                applied_reg <= target_reg;
            end
        end else if (state_reg == gcc_pkg::GCC_ST_RAMP && tick) begin
            if (applied_reg < target_reg) begin
                applied_reg <= applied_reg + 1'b1;
            end else if (applied_reg > target_reg) begin
                applied_reg <= applied_reg - 1'b1;
            end
        end
    end

    // Flag each half-dB step actually taken
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            step_reg <= 1'b0;
        end else begin
            step_reg <= !gain_load && tick
                        && (state_reg == gcc_pkg::GCC_ST_RAMP)
                        && (applied_reg != target_reg);
        end
    end

    // The ramp is only clean up to the impedance-dependent ceiling;
    // software owns that limit, this flag only reports a breach
    assign limit = impedance_20k ? gcc_pkg::GCC_LIMIT_20K : gcc_pkg::GCC_LIMIT_10K;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            warn_reg <= 1'b0;
        end else begin
            warn_reg <= soft_sel && (target_reg > limit);
        end
    end

    // Outputs
    assign reg_rdata             = rdata_reg;
    assign reg_rvalid            = rvalid_reg;
    assign reg_hit               = hit_reg;
    assign enhancer_threshold_db = thr_db_reg;
    assign enhancer_max_gain_db  = emax_db_reg;
    assign auto_gain_target_db   = atgt_db_reg;
    assign auto_gain_max_gain_db = amax_db_reg;
    assign gain_applied          = applied_reg;
    assign gain_busy             = (state_reg != gcc_pkg::GCC_ST_IDLE);
    assign gain_step             = step_reg;
    assign gain_limit_warn       = warn_reg;
endmodule
`default_nettype wire

//--- shared/gcc_pkg.sv
// Shared constants and types of the gain control configuration block
package gcc_pkg;
    // Register offsets on the control port
    localparam logic [7:0] GCC_RANGE_ENHANCER_CFG_OFS = 8'h6d;
    localparam logic [7:0] GCC_AUTO_GAIN_CFG_OFS      = 8'h70;
    localparam logic [7:0] GCC_GAIN_CHANGE_CFG_OFS    = 8'h71;

    // Values after reset
    localparam logic [7:0] GCC_RANGE_ENHANCER_CFG_RST = 8'h7b;
    localparam logic [7:0] GCC_AUTO_GAIN_CFG_RST      = 8'he7;
    localparam logic [7:0] GCC_GAIN_CHANGE_CFG_RST    = 8'h00;

    // Field positions: upper nibble, lower nibble, method pair, spare bit
    localparam int GCC_HI_NIB_LSB   = 4;
    localparam int GCC_LO_NIB_LSB   = 0;
    localparam int GCC_METHOD_LSB   = 6;
    localparam int GCC_SPARE_RW_BIT = 5;

    // Gain change methods
    localparam logic [1:0] GCC_METHOD_IMMEDIATE = 2'h0;
    localparam logic [1:0] GCC_METHOD_REDUCED   = 2'h1;
    localparam logic [1:0] GCC_METHOD_STEP_FAST = 2'h2;
    localparam logic [1:0] GCC_METHOD_STEP_SLOW = 2'h3;

    // Timing of the soft-step ramp
    localparam int GCC_CLK_PERIOD_NS = 10;
    localparam int GCC_STEP_FAST_US  = 20;
    localparam int GCC_STEP_SLOW_US  = 40;
    localparam int GCC_STEP_FAST_CYC = GCC_STEP_FAST_US * 1000 / GCC_CLK_PERIOD_NS;
    localparam int GCC_STEP_SLOW_CYC = GCC_STEP_SLOW_US * 1000 / GCC_CLK_PERIOD_NS;
    localparam int GCC_TICK_W        = 12;

    // Longest wait for a zero crossing in the reduced-artifact method
    localparam int GCC_ZC_TIMEOUT_US  = 1000;
    localparam int GCC_ZC_TIMEOUT_CYC = GCC_ZC_TIMEOUT_US * 1000 / GCC_CLK_PERIOD_NS;

    // Channel gain in half-dB units, one unit per ramp step
    localparam int GCC_GAIN_W = 7;
    localparam logic [6:0] GCC_LIMIT_10K = 7'h3c;
    localparam logic [6:0] GCC_LIMIT_20K = 7'h30;

    // Decoded levels in whole dB: base of code 0 and step per code
    localparam logic [6:0] GCC_THR_BASE   = 7'h0c;
    localparam logic [2:0] GCC_THR_STEP   = 3'h6;
    localparam logic [6:0] GCC_EMAX_BASE  = 7'h02;
    localparam logic [2:0] GCC_EMAX_STEP  = 3'h2;
    localparam logic [6:0] GCC_ATGT_BASE  = 7'h06;
    localparam logic [2:0] GCC_ATGT_STEP  = 3'h2;
    localparam logic [6:0] GCC_AMAX_BASE  = 7'h03;
    localparam logic [2:0] GCC_AMAX_STEP  = 3'h3;

    // Gain change sequencer states
    typedef enum logic [2:0] {
        GCC_ST_IDLE    = 3'h1,
        GCC_ST_WAIT_ZC = 3'h2,
        GCC_ST_RAMP    = 3'h4
    } gcc_state_t;
endpackage

//--- logic/gcc_level_decode.sv
// Decoder from configuration codes to level magnitudes in whole dB
`timescale 1ns/100ps
`default_nettype none
module gcc_level_decode (
    // Configuration codes
    input  wire logic [3:0] thr_code,
    input  wire logic [3:0] emax_code,
    input  wire logic [3:0] atgt_code,
    input  wire logic [3:0] amax_code,
    // Magnitudes in dB (threshold and target are negative levels)
    output logic      [6:0] thr_db,
    output logic      [6:0] emax_db,
    output logic      [6:0] atgt_db,
    output logic      [6:0] amax_db
);
    // Linear code map: reserved codes simply extend the line
    function automatic logic [6:0] gcc_lin(input logic [3:0] code,
                                           input logic [6:0] base,
                                           input logic [2:0] step);
        gcc_lin = base + 7'(code) * 7'(step);
    endfunction

    // Threshold falls 6 dB per code from -12 dB
    assign thr_db  = gcc_lin(thr_code, gcc_pkg::GCC_THR_BASE,
                             gcc_pkg::GCC_THR_STEP);
    // Enhancer gain ceiling rises 2 dB per code from 2 dB
    assign emax_db = gcc_lin(emax_code, gcc_pkg::GCC_EMAX_BASE,
                             gcc_pkg::GCC_EMAX_STEP);
    // Target level falls 2 dB per code from -6 dB
    assign atgt_db = gcc_lin(atgt_code, gcc_pkg::GCC_ATGT_BASE,
                             gcc_pkg::GCC_ATGT_STEP);
    // Controller gain ceiling rises 3 dB per code from 3 dB
    assign amax_db = gcc_lin(amax_code, gcc_pkg::GCC_AMAX_BASE,
                             gcc_pkg::GCC_AMAX_STEP);
endmodule
`default_nettype wire

//--- logic/gcc_step_tick.sv
// Divider that paces the soft-step ramp with one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module gcc_step_tick #(
    parameter int FAST_CYC = gcc_pkg::GCC_STEP_FAST_CYC,
    parameter int SLOW_CYC = gcc_pkg::GCC_STEP_SLOW_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Control
    input  wire logic run,
    input  wire logic slow,
    // Pace pulse
    output logic      tick
);
    localparam int TW = gcc_pkg::GCC_TICK_W;

    logic [TW-1:0] cnt_reg;  // Cycles since the last pulse
    logic [TW-1:0] last;     // Terminal count of the chosen rate

    // Rate may change mid-ramp; the new terminal count applies at once to the period in progress
    assign last = slow ? TW'(SLOW_CYC - 1) : TW'(FAST_CYC - 1);

    // Count only while ramping so the first step is a full period away
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (!run || cnt_reg >= last) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Pulse on the terminal count
    assign tick = run && (cnt_reg >= last);
endmodule
`default_nettype wire

//--- testbench/gcc_gain_control_config_sva.sv
// Checker of register and gain sequencer behaviour at the block's ports
`timescale 1ns/100ps
`default_nettype none
module gcc_gain_control_config_sva #(
    parameter int ZC_TIMEOUT_CYCLES = 20
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       reg_hit,
    // Gain request and results
    input wire logic [6:0] gain_target,
    input wire logic       gain_load,
    input wire logic [6:0] gain_applied,
    input wire logic       gain_busy,
    // Fields
    input wire logic [3:0] enhancer_trigger_threshold,
    input wire logic [3:0] enhancer_max_gain,
    input wire logic [3:0] auto_gain_target_level,
    input wire logic [3:0] auto_gain_max_gain,
    input wire logic [1:0] live_gain_change_method,
    input wire logic [6:0] enhancer_threshold_db
);
    // All checks share one clock and reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Longest stay in the zero-crossing wait, counted from the load edge
    localparam int ZC_LIMIT = ZC_TIMEOUT_CYCLES + 1;
    a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
    a_hit_decode: assert property (reg_rd |=>
        reg_hit == ($past(reg_addr) inside {8'h6d, 8'h70, 8'h71}))
        else $error("hit flag wrong");
    a_enh_write: assert property (reg_wr && reg_addr == 8'h6d |=>
        {enhancer_trigger_threshold, enhancer_max_gain} == $past(reg_wdata))
        else $error("enhancer write lost");
    a_agc_write: assert property (reg_wr && reg_addr == 8'h70 |=>
        {auto_gain_target_level, auto_gain_max_gain} == $past(reg_wdata))
        else $error("controller write lost");
    a_method_write: assert property (reg_wr && reg_addr == 8'h71 |=>
        live_gain_change_method == $past(reg_wdata[7:6])) else $error("method write lost");
    a_spare_zero: assert property (reg_rd && reg_addr == 8'h71 |=>
        reg_rdata[4:0] == 5'h00) else $error("read-only bits not zero");
    a_thr_decode: assert property ($past(rstn) |->
        enhancer_threshold_db == 7'h0c + 7'h06 * {3'h0, $past(enhancer_trigger_threshold)})
        else $error("threshold decode");
    a_immediate_gain: assert property (gain_load && live_gain_change_method == 2'h0 |=>
        gain_applied == $past(gain_target) && !gain_busy) else $error("gain not immediate");
    a_ramp_busy: assert property (gain_load && live_gain_change_method[1] |=>
        gain_busy) else $error("ramp not busy");
    a_zc_bound: assert property (gain_load && live_gain_change_method == 2'h1 |->
        ##[1:ZC_LIMIT] (!gain_busy || gain_load)) else $error("zero-crossing wait too long");
endmodule
bind gcc_gain_control_config gcc_gain_control_config_sva #(
    .ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)) u_sva (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .gain_target(gain_target), .gain_load(gain_load), .gain_applied(gain_applied),
    .gain_busy(gain_busy), .enhancer_trigger_threshold(enhancer_trigger_threshold),
    .enhancer_max_gain(enhancer_max_gain), .auto_gain_target_level(auto_gain_target_level),
    .auto_gain_max_gain(auto_gain_max_gain), .live_gain_change_method(live_gain_change_method),
    .enhancer_threshold_db(enhancer_threshold_db));
`default_nettype wire

//--- testbench/gcc_gain_control_config_bench.sv
// Self-checking bench of the gain control configuration block
`timescale 1ns/100ps
`default_nettype none
module gcc_gain_control_config_bench;
    // Stimulus and observed signals
    logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic gain_load = 1'b0, zero_cross = 1'b0, impedance_20k = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, v;
    logic [6:0] gain_target = 7'h00, gain_applied, thr_db, emax_db, atgt_db, amax_db;
    logic [3:0] thr, emax, atgt, amax;
    logic [1:0] method;
    logic rvalid, hit, h, busy, step, warn;
    logic [7:0] mdl [3];       // Expected register contents
    logic [7:0] ofs [3] = '{8'h6d, 8'h70, 8'h71};
    integer seed = 9713;
    int errors = 0, num_checks = 0, cyc = 0, n, k;
    // Short zero-crossing timeout keeps the reduced-artifact test brief
    gcc_gain_control_config #(.ZC_TIMEOUT_CYCLES(20)) DUT (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(rvalid), .reg_hit(hit), .gain_target(gain_target),
        .gain_load(gain_load), .zero_cross(zero_cross), .impedance_20k(impedance_20k),
        .enhancer_trigger_threshold(thr), .enhancer_max_gain(emax),
        .auto_gain_target_level(atgt), .auto_gain_max_gain(amax),
        .live_gain_change_method(method), .enhancer_threshold_db(thr_db),
        .enhancer_max_gain_db(emax_db), .auto_gain_target_db(atgt_db),
        .auto_gain_max_gain_db(amax_db), .gain_applied(gain_applied), .gain_busy(busy),
        .gain_step(step), .gain_limit_warn(warn));
    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            test_done;
        end
    end
    // Compare one value
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Linear decode: base plus step per code
    function logic [7:0] lin(input logic [7:0] b, input logic [7:0] s, input logic [3:0] c);
        return b + s * {4'h0, c};
    endfunction
    // Register write, one-cycle strobe
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Register read; answer lands one cycle after the strobe is taken
    task rd(input logic [7:0] a, output logic [7:0] q, output logic ht);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
        ht = hit;
        chk("rvalid", {7'h0, rvalid}, 8'h01);
    endtask
    // Gain request pulse
    task load(input logic [6:0] t);
        @(posedge core_clk);
        gain_target <= t;
        gain_load <= 1'b1;
        @(posedge core_clk);
        gain_load <= 1'b0;
    endtask
    // Count cycles until the next ramp step, bounded
    task wait_step(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            #1;
            c++;
        end while (step !== 1'b1 && c < 5000);
    endtask
    // Read back all registers and compare fields and decoded levels
    task chk_regs;
        for (int i = 0; i < 3; i++) begin
            rd(ofs[i], d, h);
            chk("reg", d, mdl[i]);
            chk("hit", {7'h0, h}, 8'h01);
        end
        chk("thr", {4'h0, thr}, {4'h0, mdl[0][7:4]});
        chk("emax", {4'h0, emax}, {4'h0, mdl[0][3:0]});
        chk("atgt", {4'h0, atgt}, {4'h0, mdl[1][7:4]});
        chk("amax", {4'h0, amax}, {4'h0, mdl[1][3:0]});
        chk("method", {6'h0, method}, {6'h0, mdl[2][7:6]});
        chk("thr_db", {1'b0, thr_db}, lin(8'h0c, 8'h06, mdl[0][7:4]));
        chk("emax_db", {1'b0, emax_db}, lin(8'h02, 8'h02, mdl[0][3:0]));
        chk("atgt_db", {1'b0, atgt_db}, lin(8'h06, 8'h02, mdl[1][7:4]));
        chk("amax_db", {1'b0, amax_db}, lin(8'h03, 8'h03, mdl[1][3:0]));
    endtask
    // Verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        mdl = '{8'h7b, 8'he7, 8'h00};
        chk_regs;
        rd(8'h6e, d, h);
        chk("unmapped", d, 8'h00);
        chk("unmapped hit", {7'h0, h}, 8'h00);
        $display("reset and unmapped test done");
        // Random writes, reserved codes left out, and an unmapped offset among them
        for (int i = 0; i < 20; i++) begin
            k = $unsigned($random(seed)) % 4;
            v = 8'($random(seed));
            if (k == 0) v = {4'(v[7:4] % 10), 4'(v[3:0] % 13)};
            if (k == 1) v[3:0] = 4'(v[3:0] % 14);
            if (k == 2) v = v & 8'hc0;
            wr((k == 3) ? 8'h6e : ofs[k], v);
            if (k < 3) mdl[k] = v;
            chk_regs;
        end
        $display("random register test done");
        wr(8'h71, 8'h00);
        load(7'h0a);
        @(posedge core_clk);
        #1;
        chk("m0 applied", {1'b0, gain_applied}, 8'h0a);
        chk("m0 busy", {7'h0, busy}, 8'h00);
        $display("immediate test done");
        wr(8'h71, 8'h40);
        load(7'h14);
        @(posedge core_clk);
        #1;
        chk("m1 busy", {7'h0, busy}, 8'h01);
        chk("m1 held", {1'b0, gain_applied}, 8'h0a);
        zero_cross <= 1'b1;
        @(posedge core_clk);
        zero_cross <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("m1 zc", {1'b0, gain_applied}, 8'h14);
        chk("m1 idle", {7'h0, busy}, 8'h00);
        load(7'h05);
        repeat (18) @(posedge core_clk);
        #1;
        chk("m1 wait", {1'b0, gain_applied}, 8'h14);
        repeat (7) @(posedge core_clk);
        #1;
        chk("m1 timeout", {1'b0, gain_applied}, 8'h05);
        $display("reduced artifact test done");
        wr(8'h71, 8'h80);
        load(7'h07);
        wait_step(n);
        chk("m2 first", {7'h0, n >= 1998 && n <= 2002}, 8'h01);
        chk("m2 step1", {1'b0, gain_applied}, 8'h06);
        wait_step(n);
        chk("m2 pace", {7'h0, n == 2000}, 8'h01);
        chk("m2 step2", {1'b0, gain_applied}, 8'h07);
        repeat (2) @(posedge core_clk);
        #1;
        chk("m2 idle", {7'h0, busy}, 8'h00);
        wr(8'h71, 8'hc0);
        load(7'h06);
        wait_step(n);
        chk("m3 pace", {7'h0, n >= 3998 && n <= 4002}, 8'h01);
        chk("m3 step", {1'b0, gain_applied}, 8'h06);
        $display("soft step test done");
        // Limit edges: 60 and 48 half-dB units pass, one more warns
        wr(8'h71, 8'h80);
        for (int i = 0; i < 4; i++) begin
            impedance_20k <= (i > 1);
            load(7'((i < 2) ? 7'h3d - i : 7'h31 - (i - 2)));
            repeat (3) @(posedge core_clk);
            #1;
            chk("warn", {7'h0, warn}, {7'h0, ~i[0]});
        end
        $display("limit warning test done");
        test_done;
    end
endmodule
`default_nettype wire
